// ===== inc/e3rxi_pkg.sv
// Package for the E3 receive alarm interrupt block: register map, fields, states
package e3rxi_pkg;

   // Register byte addresses (APB, one aligned word each)
   localparam logic [7:0] E3RXI_ADDR_ENABLE    = 8'h4C; // index 8'h13
   localparam logic [7:0] E3RXI_ADDR_STATUS    = 8'h50; // index 8'h14
   localparam logic [7:0] E3RXI_ADDR_AENABLE   = 8'h48; // index 8'h12
   localparam logic [7:0] E3RXI_ADDR_STATUS2   = 8'h54;
   localparam logic [7:0] E3RXI_ADDR_CONFIG    = 8'h40;
   localparam logic [7:0] E3RXI_ADDR_STATE     = 8'h44;
   localparam logic [7:0] E3RXI_IDX_ENABLE     = 8'h13;
   localparam logic [7:0] E3RXI_IDX_STATUS     = 8'h14;

   // Reset values
   localparam logic [7:0] E3RXI_RST_BYTE       = 8'h00;
   // Writable bits of the enable registers (bit 7 not used)
   localparam logic [7:0] E3RXI_EN2_MASK       = 8'h7F;
   localparam logic [7:0] E3RXI_EN1_MASK       = 8'h7F;
   // Sync message bits (6 and 5) of status one
   localparam logic [7:0] E3RXI_SSM_MASK       = 8'h60;
   // Status two: bit 5 reads zero there (LAPD status bit is kept internally only)
   localparam logic [7:0] E3RXI_ST2_MASK       = 8'h5F;

   // Framing-byte error frames needed to declare out of frame
   localparam logic [2:0] E3RXI_OOF_ERR_FRAMES = 3'h4;
   // Consecutive zero bits that mark loss of signal
   localparam logic [5:0] E3RXI_LOS_ZEROS      = 6'h20;

   // Field positions
   localparam int E3RXI_B_TTB   = 6;
   localparam int E3RXI_B_LAPD  = 5;
   localparam int E3RXI_B_FAR_END_BLOCK_ERROR  = 4;
   localparam int E3RXI_B_FAR_END_RECEIVE_FAILURE  = 3;
   localparam int E3RXI_B_EM    = 2;
   localparam int E3RXI_B_FBE   = 1;
   localparam int E3RXI_B_PLD   = 0;
   localparam int E3RXI_B_SSM   = 6;
   localparam int E3RXI_B_SEQ   = 5;
   localparam int E3RXI_B_FRAME_ALIGNMENT_CHANGE  = 4;
   localparam int E3RXI_B_OOF   = 3;
   localparam int E3RXI_B_LOF   = 2;
   localparam int E3RXI_B_LOS   = 1;
   localparam int E3RXI_B_AIS   = 0;
   localparam int E3RXI_B_REV95 = 0;

   // Framing acquisition/maintenance states, one-hot
   typedef enum logic [3:0] {
      E3RXI_ST_INFRAME = 4'h1,
      E3RXI_ST_OOF     = 4'h2,
      E3RXI_ST_LOF     = 4'h4,
      E3RXI_ST_VERIFY  = 4'h8
   } e3rxi_state_t;

   // Per-frame and per-bit events from the receive framer
   typedef struct packed {
      logic frame_end;      // One pulse per received frame
      logic fa_error;       // Framing octets errored in this frame
      logic fa_found;       // Framing octets found during acquisition
      logic fa_verified;    // Alignment confirmed in verification
      logic lof_timeout;    // Out of frame lasted long enough for loss
      logic frame_alignment_change;           // Frame alignment changed
      logic ssm_change;     // Sync status message contents changed
      logic ssm_seq_lock;   // Level: in sequence with the sync message
      logic far_end_receive_failure;           // Level: far end receive failure declared
      logic alarm_indication;            // Level: alarm indication declared
      logic ttb_new;        // New trail trace message start
      logic lapd_msg;       // LAPD message frame received
      logic far_end_block_error;           // Far end block error seen
      logic em_error;       // Error monitor byte parity error
      logic pld_mismatch;   // Payload type changed from last frame
      logic bit_valid;      // One pulse per received line bit
      logic bit_value;      // Line bit value
   } e3rxi_evt_t;

   // Pending mask of status register: bits set in both status and enable
   function automatic logic [7:0] e3rxi_pend(input logic [7:0] st, input logic [7:0] en);
      e3rxi_pend = st & en;
   endfunction

endpackage

// ===== hw/e3rxi_top.sv
// E3 receive alarm interrupt logic: enables, clear-on-read status, framing tracker
//
// Operation
// R1 - Enable bit 6 gates trail trace change
// R2 - Enable bit 5 gates LAPD message interrupt
// R3 - Enable bit 4 gates far end block error
// R4 - Enable bit 3 gates far end failure change
// R5 - Enable bit 2 gates error monitor byte error
// R6 - Enable bit 1 gates framing byte error
// R7 - Enable bit 0 gates payload type mismatch
// R8 - Status bit 6 latches sync message change
// R9 - Sync message bits invalid in 1995 format
// R10 - Status bit 5 on sequence loss or regain
// R11 - Status bit 4 on frame alignment change
// R12 - Status bit 3 on out of frame, in-frame
// R13 - Status bit 2 on loss, and verify-to-in-frame
// R14 - Reading status clears all its event bits
// R15 - Status one means event since last read
// R16 - Status bit 1 on loss of signal change
// R17 - Status bit 0 on alarm indication change
// R18 - Four errored framing frames declare out of frame
// R19 - Interrupt while status and enable both set
`timescale 1ns/1ps
`default_nettype none
module e3rxi_top (
   // Clock and reset
   input  wire logic                mclk_i,
   input  wire logic                rst_i,
   // APB slave
   input  wire logic                psel_i,
   input  wire logic                penable_i,
   input  wire logic                pwrite_i,
   input  wire logic [7:0]          paddr_i,
   input  wire logic [31:0]         pwdata_i,
   output logic      [31:0]         prdata_o,
   output logic                     pready_o,
   output logic                     pslverr_o,
   // Framer events, same clock
   input  wire e3rxi_pkg::e3rxi_evt_t evt_i,
   // Interrupt
   output logic                     irq_o
);
   import e3rxi_pkg::*;

   // Registers
   logic [7:0]   enable_two;
   logic [7:0]   enable_one;
   logic [7:0]   status_one;
   logic [7:0]   status_two;
   logic         rev1995;
   e3rxi_state_t frm_state;
   e3rxi_state_t next_frm_state;
   logic [2:0]   err_run;
   logic [5:0]   zero_run;
   logic         loss_of_signal;
   logic         seq_lock_q;
   logic         far_end_receive_failure_q;
   logic         ais_q;
   logic         los_q;
   logic [7:0]   set_one;
   logic [7:0]   set_two;
   logic         wr_en;
   logic         rd_en;
   logic         rd_st1;
   logic         rd_st2;
   logic         hit;
   logic [7:0]   rd_byte;

   // APB access phase; the slave answers with no wait state
   assign wr_en     = psel_i & penable_i & pwrite_i;
   assign rd_en     = psel_i & penable_i & ~pwrite_i;
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~hit;
   assign rd_st1    = rd_en & (paddr_i == E3RXI_ADDR_STATUS);
   assign rd_st2    = rd_en & (paddr_i == E3RXI_ADDR_STATUS2);

   // Address decode and read mux
   always_comb begin
      hit     = 1'b1;
      rd_byte = E3RXI_RST_BYTE;
      case (paddr_i)
         E3RXI_ADDR_ENABLE:  rd_byte = enable_two;
         E3RXI_ADDR_AENABLE: rd_byte = enable_one;
         E3RXI_ADDR_STATUS:  rd_byte = status_one;
         E3RXI_ADDR_STATUS2: rd_byte = status_two & E3RXI_ST2_MASK; // LAPD bit hidden, see R2
         E3RXI_ADDR_CONFIG:  rd_byte = {7'h00, rev1995};
         E3RXI_ADDR_STATE:   rd_byte = {ais_q, los_q, far_end_receive_failure_q, seq_lock_q, frm_state};
         default:            hit     = 1'b0;
      endcase
   end

   // Read data is registered so the bus sees a stable flop output
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         prdata_o <= 32'h0000_0000;
      end else if (rd_en) begin
         prdata_o <= {24'h000000, rd_byte};
      end
   end

   // Enable and configuration registers
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         enable_two <= E3RXI_RST_BYTE;
         enable_one <= E3RXI_RST_BYTE;
         rev1995    <= 1'b0;
      end else if (wr_en) begin
         case (paddr_i)
            E3RXI_ADDR_ENABLE:  enable_two <= pwdata_i[7:0] & E3RXI_EN2_MASK; // see R1
            E3RXI_ADDR_AENABLE: enable_one <= pwdata_i[7:0] & E3RXI_EN1_MASK;
            E3RXI_ADDR_CONFIG:  rev1995    <= pwdata_i[E3RXI_B_REV95];
            default:            rev1995    <= rev1995;
         endcase
      end
   end

   // Framing acquisition and maintenance state machine
   always_comb begin
      next_frm_state = frm_state;
      case (frm_state)
         E3RXI_ST_INFRAME: begin
            if (evt_i.frame_end && evt_i.fa_error && err_run == E3RXI_OOF_ERR_FRAMES - 3'h1) begin
               next_frm_state = E3RXI_ST_OOF; // see R18
            end
         end
         E3RXI_ST_OOF: begin
            if (evt_i.lof_timeout) begin
               next_frm_state = E3RXI_ST_LOF;
            end else if (evt_i.fa_found) begin
               next_frm_state = E3RXI_ST_VERIFY;
            end
         end
         E3RXI_ST_LOF: begin
            if (evt_i.fa_found) begin
               next_frm_state = E3RXI_ST_VERIFY;
            end
         end
         E3RXI_ST_VERIFY: begin
            if (evt_i.fa_verified) begin
               next_frm_state = E3RXI_ST_INFRAME;
            end else if (evt_i.fa_error) begin
               next_frm_state = E3RXI_ST_OOF;
            end
         end
         default: next_frm_state = E3RXI_ST_OOF;
      endcase
   end

   // Framer starts hunting after reset
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         frm_state <= E3RXI_ST_OOF;
      end else begin
         frm_state <= next_frm_state;
      end
   end

   // Count consecutive errored frames while in frame
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         err_run <= 3'h0;
      end else if (frm_state != E3RXI_ST_INFRAME) begin
         err_run <= 3'h0;
      end else if (evt_i.frame_end) begin
         err_run <= evt_i.fa_error ? err_run + 3'h1 : 3'h0; // see R18
      end
   end

   // Loss of signal: run of zeros; any one bit ends it (simplified recovery)
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         zero_run <= 6'h00;
         loss_of_signal      <= 1'b0;
      end else if (evt_i.bit_valid) begin
         if (evt_i.bit_value) begin
            zero_run <= 6'h00;
            loss_of_signal      <= 1'b0;
         end else if (zero_run == E3RXI_LOS_ZEROS - 6'h01) begin
            loss_of_signal      <= 1'b1; // see R16
         end else begin
            zero_run <= zero_run + 6'h01;
         end
      end
   end

   // Previous levels for change detection
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         seq_lock_q <= 1'b0;
         far_end_receive_failure_q     <= 1'b0;
         ais_q      <= 1'b0;
         los_q      <= 1'b0;
      end else begin
         seq_lock_q <= evt_i.ssm_seq_lock;
         far_end_receive_failure_q     <= evt_i.far_end_receive_failure;
         ais_q      <= evt_i.alarm_indication;
         los_q      <= loss_of_signal;
      end
   end

   // Event sets for status one
   always_comb begin
      set_one = E3RXI_RST_BYTE;
      set_one[E3RXI_B_SSM]  = evt_i.ssm_change;                              // see R8
      set_one[E3RXI_B_SEQ]  = evt_i.ssm_seq_lock ^ seq_lock_q;               // see R10
      set_one[E3RXI_B_FRAME_ALIGNMENT_CHANGE] = evt_i.frame_alignment_change;                                    // see R11
      set_one[E3RXI_B_OOF]  = (next_frm_state == E3RXI_ST_OOF && frm_state == E3RXI_ST_INFRAME)
                            | (next_frm_state == E3RXI_ST_INFRAME
                               && frm_state != E3RXI_ST_INFRAME);            // see R12
      set_one[E3RXI_B_LOF]  = (frm_state == E3RXI_ST_OOF && next_frm_state == E3RXI_ST_LOF)
                            | (frm_state == E3RXI_ST_VERIFY
                               && next_frm_state == E3RXI_ST_INFRAME);       // see R13
      set_one[E3RXI_B_LOS]  = loss_of_signal ^ los_q;                                   // see R16
      set_one[E3RXI_B_AIS]  = evt_i.alarm_indication ^ ais_q;                             // see R17
      if (rev1995) begin
         set_one = set_one & ~E3RXI_SSM_MASK;                                // see R9
      end
   end

   // Event sets for the second status byte
   always_comb begin
      set_two = E3RXI_RST_BYTE;
      set_two[E3RXI_B_TTB]  = evt_i.ttb_new;
      set_two[E3RXI_B_LAPD] = evt_i.lapd_msg;
      set_two[E3RXI_B_FAR_END_BLOCK_ERROR] = evt_i.far_end_block_error;
      set_two[E3RXI_B_FAR_END_RECEIVE_FAILURE] = evt_i.far_end_receive_failure ^ far_end_receive_failure_q;
      set_two[E3RXI_B_EM]   = evt_i.em_error;
      set_two[E3RXI_B_FBE]  = evt_i.frame_end & evt_i.fa_error;
      set_two[E3RXI_B_PLD]  = evt_i.pld_mismatch;
   end

   // Status one: sticky, cleared by read; a new event beats the clear
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         status_one <= E3RXI_RST_BYTE;
      end else begin
         status_one <= ((rd_st1 ? E3RXI_RST_BYTE : status_one) | set_one)
                       & E3RXI_EN1_MASK; // see R14 see R15
      end
   end

   // Status two keeps LAPD pending internally only; it reads zero on bit 5
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         status_two <= E3RXI_RST_BYTE;
      end else begin
         status_two <= ((rd_st2 ? E3RXI_RST_BYTE : status_two) | set_two)
                       & E3RXI_EN2_MASK; // see R14
      end
   end

   // Interrupt: enables gate each event; status one uses its own enables
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |e3rxi_pend(status_two, enable_two)   // see R1 see R2 see R3 see R4
                | |e3rxi_pend(status_one, enable_one
                              & (rev1995 ? ~E3RXI_SSM_MASK : E3RXI_EN1_MASK)); // see R19 see R5 see R6 see R7
      end
   end

endmodule
`default_nettype wire

// ===== testbench/e3rxi_assertions.sv
// Port-level checker for the E3 receive alarm interrupt block
`timescale 1ns/1ps
`default_nettype none
module e3rxi_assertions
   import e3rxi_pkg::*;
(
   // Clock and reset
   input wire logic                   mclk_i,
   input wire logic                   rst_i,
   // APB
   input wire logic                   psel_i,
   input wire logic                   penable_i,
   input wire logic                   pwrite_i,
   input wire logic [7:0]             paddr_i,
   input wire logic [31:0]            pwdata_i,
   input wire logic [31:0]            prdata_o,
   input wire logic                   pready_o,
   input wire logic                   pslverr_o,
   // Events and interrupt
   input wire e3rxi_pkg::e3rxi_evt_t  evt_i,
   input wire logic                   irq_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   logic       acc;
   logic       mapped;
   logic [3:0] seen2;
   logic       seen_frame_alignment_change;
   logic [7:0] en1_q;
   logic [7:0] en2_q;
   logic [7:0] exp2;
   // Access edge decode; only six words answer
   assign acc = psel_i && penable_i;
   assign mapped = paddr_i inside {8'h40, 8'h44, 8'h48, 8'h4C, 8'h50, 8'h54};
   assign exp2 = {1'b0, seen2[3], 1'b0, seen2[2], 1'b0, seen2[1], 1'b0, seen2[0]};
   // Events since last status read; an event on the read edge survives it
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         seen2     <= 4'h0;
         seen_frame_alignment_change <= 1'b0;
      end else begin
         seen2 <= ((acc && !pwrite_i && paddr_i == E3RXI_ADDR_STATUS2) ? 4'h0 : seen2)
                  | {evt_i.ttb_new, evt_i.far_end_block_error, evt_i.em_error, evt_i.pld_mismatch};
         seen_frame_alignment_change <= ((acc && !pwrite_i && paddr_i == E3RXI_ADDR_STATUS) ? 1'b0 : seen_frame_alignment_change)
                      | evt_i.frame_alignment_change;
      end
   end
   // Shadow of both enable registers
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         en1_q <= 8'h00;
         en2_q <= 8'h00;
      end else if (acc && pwrite_i) begin
         if (paddr_i == E3RXI_ADDR_AENABLE) en1_q <= pwdata_i[7:0] & E3RXI_EN1_MASK;
         if (paddr_i == E3RXI_ADDR_ENABLE) en2_q <= pwdata_i[7:0] & E3RXI_EN2_MASK;
      end
   end
   sequence s_read(a);
      acc && !pwrite_i && paddr_i == a;
   endsequence
   AST_READY_HIGH: assert property (pready_o)
      else $error("pready low");
   AST_SLVERR_MAP: assert property (pslverr_o == (acc && !mapped))
      else $error("pslverr does not follow address map");
   AST_RDATA_UPPER: assert property (prdata_o[31:8] == 24'h000000)
      else $error("read data upper bits set");
   AST_UNMAPPED_ZERO: assert property ((acc && !pwrite_i && !mapped) |=> prdata_o == 32'h0)
      else $error("unmapped read not zero");
   AST_EN2_READBACK: assert property (
      s_read(E3RXI_ADDR_ENABLE) |=> prdata_o[7:0] == $past(en2_q))
      else $error("enable two readback wrong");
   AST_FRAME_ALIGNMENT_CHANGE_LATCH: assert property (
      s_read(E3RXI_ADDR_STATUS) |=> prdata_o[4] == $past(seen_frame_alignment_change))
      else $error("frame alignment status wrong");
   AST_ST2_LATCH: assert property (
      s_read(E3RXI_ADDR_STATUS2) |=> (prdata_o[7:0] & 8'hF5) == $past(exp2))
      else $error("status two pulse bits wrong");
   AST_IRQ_GATED: assert property (
      (en1_q == 8'h00 && en2_q == 8'h00) [*2] |-> !irq_o)
      else $error("interrupt with all enables off");
endmodule
bind e3rxi_top e3rxi_assertions u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .evt_i(evt_i),
   .irq_o(irq_o));
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench for the E3 receive alarm interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import e3rxi_pkg::*;
   logic        mclk_i, rst_i, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdat;
   e3rxi_evt_t  evt, lvl, e;
   int          failures, checks, b;
   e3rxi_top uut (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .evt_i(evt), .irq_o(irq));
   // 25 MHz clock
   initial begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // One APB transfer; read data is loaded at the access edge, so take it one edge later
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         failures++;
         final_report();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk_i);
      rdat = prdata;
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, rdat, {24'h000000, exp});
   endtask
   // Drive an event for n cycles on top of the held level inputs
   task automatic fire(input e3rxi_evt_t p, input int n);
      repeat (n) begin
         @(posedge mclk_i);
         evt <= e3rxi_evt_t'(p | lvl);
      end
      @(posedge mclk_i);
      evt <= lvl;
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      evt = '0;
      lvl = '0;
      failures = 0;
      checks = 0;
      rst_i = 1'b1;
      repeat (3) @(posedge mclk_i);
      rst_i <= 1'b0;
      rchk("enable_two", E3RXI_ADDR_ENABLE, E3RXI_RST_BYTE);
      rchk("status_one", E3RXI_ADDR_STATUS, E3RXI_RST_BYTE);
      apb(1'b1, E3RXI_ADDR_ENABLE, 32'hFFFFFFFF);
      rchk("enable_two_mask", E3RXI_ADDR_ENABLE, E3RXI_EN2_MASK);
      // Each enable bit gates only its own event; bit 5 raises irq but reads zero
      for (b = 0; b < 7; b++) begin
         e = '0;
         case (b)
            0: e.pld_mismatch = 1'b1;
            1: {e.frame_end, e.fa_error} = 2'b11;
            2: e.em_error = 1'b1;
            3: lvl.far_end_receive_failure = ~lvl.far_end_receive_failure;
            4: e.far_end_block_error = 1'b1;
            5: e.lapd_msg = 1'b1;
            default: e.ttb_new = 1'b1;
         endcase
         apb(1'b1, E3RXI_ADDR_ENABLE, 32'h7F ^ (32'h1 << b));
         fire(e, 1);
         repeat (3) @(posedge mclk_i);
         chk("irq_off", {31'h0, irq}, 32'h0);
         apb(1'b1, E3RXI_ADDR_ENABLE, 32'h1 << b);
         repeat (2) @(posedge mclk_i);
         chk("irq_on", {31'h0, irq}, 32'h1);
         rchk("status_two", E3RXI_ADDR_STATUS2, (b == 5) ? 8'h00 : 8'h01 << b);
         rchk("status_two_clr", E3RXI_ADDR_STATUS2, 8'h00);
         chk("irq_clr", {31'h0, irq}, 32'h0);
      end
      // Status one, every source enabled
      apb(1'b1, E3RXI_ADDR_AENABLE, 32'h7F);
      e = '0;
      e.frame_alignment_change = 1'b1;
      fire(e, 1);
      repeat (2) @(posedge mclk_i);
      chk("irq_frame_alignment_change", {31'h0, irq}, 32'h1);
      rchk("frame_alignment_change", E3RXI_ADDR_STATUS, 8'h10);
      e = '0;
      e.ssm_change = 1'b1;
      fire(e, 1);
      rchk("ssm", E3RXI_ADDR_STATUS, 8'h40);
      // Both edges of sequence lock, then both edges of alarm indication
      for (b = 0; b < 4; b++) begin
         if (b < 2) lvl.ssm_seq_lock = ~lvl.ssm_seq_lock;
         else lvl.alarm_indication = ~lvl.alarm_indication;
         fire('0, 1);
         rchk("level_edge", E3RXI_ADDR_STATUS, (b < 2) ? 8'h20 : 8'h01);
      end
      e = '0;
      e.bit_valid = 1'b1;
      fire(e, 31);
      rchk("los_31", E3RXI_ADDR_STATUS, 8'h00);
      fire(e, 1);
      rchk("los_32", E3RXI_ADDR_STATUS, 8'h02);
      e.bit_value = 1'b1;
      fire(e, 1);
      rchk("los_end", E3RXI_ADDR_STATUS, 8'h02);
      // Acquisition, verification, four errored frames, then loss of frame
      e = '0;
      e.fa_found = 1'b1;
      fire(e, 1);
      e = '0;
      e.fa_verified = 1'b1;
      fire(e, 1);
      rchk("in_frame", E3RXI_ADDR_STATUS, 8'h0C);
      e = '0;
      {e.frame_end, e.fa_error} = 2'b11;
      fire(e, 3);
      rchk("oof_3", E3RXI_ADDR_STATUS, 8'h00);
      fire(e, 1);
      rchk("oof_4", E3RXI_ADDR_STATUS, 8'h08);
      e = '0;
      e.lof_timeout = 1'b1;
      fire(e, 1);
      rchk("lof", E3RXI_ADDR_STATUS, 8'h04);
      // Older format: sync message change raises nothing
      apb(1'b1, E3RXI_ADDR_CONFIG, 32'h1);
      apb(1'b1, E3RXI_ADDR_AENABLE, 32'h40);
      e = '0;
      e.ssm_change = 1'b1;
      fire(e, 1);
      repeat (3) @(posedge mclk_i);
      chk("irq_1995", {31'h0, irq}, 32'h0);
      apb(1'b0, E3RXI_ADDR_STATUS, 32'h0);
      rchk("unmapped", 8'h5C, 8'h00);
      final_report();
   end
endmodule
`default_nettype wire
